// file: core/irq_vec_pkg.sv
package irq_vec_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // request numbering and vector table layout
    localparam int          NUM_REQ          = 46;           // request numbers 0..45
    localparam logic [5:0]  REQ_NONE         = 6'h3F;        // no request selected
    localparam logic [23:0] PRIMARY_BASE     = 24'h000014;   // primary_vector_table entry of request 0
    localparam logic [23:0] ALTERNATE_BASE   = 24'h000114;   // alternate_vector_table entry of request 0
    localparam logic [7:0]  VECTOR_OFFSET    = 8'h08;        // vector number of request 0
    localparam logic [45:0] RESERVED_MASK    = 46'h2000_0004_8000; // requests 15, 18, 45

    // request numbers of note
    localparam int REQ_EXT0    = 0;
    localparam int REQ_DMA0    = 4;
    localparam int REQ_UART2TX = 31;
    localparam int REQ_UART2RX = 30;
    localparam int REQ_EXT2    = 29;
    localparam int REQ_TIMER5  = 28;
    localparam int REQ_COMP8   = 44;

    // sources whose priority lives in the coined registers but whose request
    // number lies beyond the vector table kept here (46 and up)
    localparam int NUM_EXTRA   = 6;   // timer6, dma_ch4, timer8, i2c2 m/s, timer7

    ////////////////////////////////////////////////////////////////////////////
    // register map (word index, chosen)
    localparam logic [3:0]  ADDR_PRIO_BASE   = 4'h0;   // indices 0..12: priority_ctrl_0..12 style
    localparam logic [3:0]  ADDR_PRIO_7      = 4'h7;
    localparam logic [3:0]  ADDR_PRIO_11     = 4'hB;
    localparam logic [3:0]  ADDR_PRIO_12     = 4'hC;
    localparam logic [3:0]  ADDR_CTRL        = 4'hD;   // bit0 table select, bits 15..1 read zero
    localparam logic [3:0]  ADDR_STATUS      = 4'hE;   // selected request and priority
    localparam logic [3:0]  ADDR_VECTOR      = 4'hF;   // selected vector address low 16 bits

    localparam logic [15:0] PRIO_RESET       = 16'h4444;   // every field 100
    localparam logic [15:0] PRIO11_MASK      = 16'h7707;   // bits 7-3 unimplemented
    localparam logic [15:0] PRIO_MASK        = 16'h7777;
    localparam logic [2:0]  PRIO_OFF         = 3'h0;       // field value that disables

    // bus carrier
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    // answer to the core
    typedef struct packed {
        logic        valid;
        logic [5:0]  req;
        logic [7:0]  vector;
        logic [23:0] addr;
        logic [2:0]  prio;
    } vec_out_t;

endpackage

// file: core/irq_vec.sv
// Operation
// - request 0 external irq 0, entries 014/114
// - request 4 dma0; entries two apart
// - requests 1,2,3 capture1, compare1, timer1
// - requests 9,10 spi1 error, done
// - requests 11,12 uart1 rx/tx; 13 adc1
// - request 14 dma1; 15 reserved
// - requests 16,17 i2c1; 18 reserved; 19 notify
// - request 20 ext irq 1; 21 adc2
// - requests 22,23 capture 7 and 8
// - request 24 dma2; 25..29 comp, timers, ext2
// - requests 30,31 uart2; 32 spi2 error
// - request 36 dma3; 34,35 can sources
// - requests 37..40 capture 3..6
// - requests 41..44 compare 5..8; 45 reserved
// - 3-bit priority field, zero disables
// - register 7 fields, reset 100, gaps zero
// - register 11 fields, bits 7-3 zero
// - register 12 fields, reset 100
// - core level is top bit over three
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module irq_vec
    import irq_vec_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire bus_req_t              bus,        // register port
    output logic [15:0]                rdata,      // read data, cycle after rd
    input  wire logic [NUM_REQ-1:0]    irq_src,    // pending flags, same clock
    input  wire logic [NUM_EXTRA-1:0]  extra_src,  // sources past request 45
    input  wire logic [2:0]            core_status_level, // status field of core
    input  wire logic                  core_level_top_bit, // core control bit
    output vec_out_t                   vec,        // registered choice
    output logic                       irq_to_core // level above core level
);

    ////////////////////////////////////////////////////////////////////////////
    // priority registers: thirteen words, four 3-bit fields each, three in word 11
    logic [15:0] prio_q [0:12];   // priority words
    logic        tbl_sel_q;       // 0 primary, 1 alternate
    logic [15:0] rdata_q;         // read data flop

    // write path and reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 13; i++) begin
                prio_q[i] <= (i == 11) ? (PRIO_RESET & PRIO11_MASK) : PRIO_RESET;
            end
        end else if (bus.wr && (bus.addr <= ADDR_PRIO_12)) begin
            // unimplemented bits never store
            if (bus.addr == ADDR_PRIO_11) begin
                prio_q[bus.addr] <= bus.wdata & PRIO11_MASK;
            end else begin
                prio_q[bus.addr] <= bus.wdata & PRIO_MASK;
            end
        end
    end

    // table select control
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tbl_sel_q <= 1'b0;
        end else if (bus.wr && bus.addr == ADDR_CTRL) begin
            tbl_sel_q <= bus.wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field extraction: request n reads word n/4, field n%4
    logic [2:0] prio_of [0:NUM_REQ-1];  // effective priority per request
    logic [NUM_REQ-1:0] live;           // pending, enabled, not reserved

    genvar g;
    generate
        for (g = 0; g < NUM_REQ; g++) begin : g_req
            // field 0 at bits 2-0 up to field 3 at bits 14-12
            assign prio_of[g] = prio_q[g / 4][(g % 4) * 4 +: 3];
            // reserved numbers are masked; zero field disables
            assign live[g] = irq_src[g] && !RESERVED_MASK[g] && (prio_of[g] != PRIO_OFF);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // arbitration: strict greater keeps the lower number on a tie
    logic [5:0] win_req;    // winning request number
    logic [2:0] win_prio;   // its priority

    always_comb begin
        win_req  = REQ_NONE;
        win_prio = PRIO_OFF;
        for (int i = 0; i < NUM_REQ; i++) begin
            if (live[i] && (prio_of[i] > win_prio)) begin
                win_req  = 6'(i);
                win_prio = prio_of[i];
            end
        end
    end

    // current core level, four bits
    logic [3:0] core_level;   // top bit above status field
    assign core_level = {core_level_top_bit, core_status_level};

    ////////////////////////////////////////////////////////////////////////////
    // vector address: base plus two per request number
    logic [23:0] win_addr;    // table entry of winner
    always_comb begin
        // consecutive requests sit two address units apart
        win_addr = (tbl_sel_q ? ALTERNATE_BASE : PRIMARY_BASE) + {17'h0, win_req, 1'b0};
    end

    // registered answer to the core
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vec <= '0;
        end else begin
            vec.valid  <= (win_req != REQ_NONE);
            vec.req    <= win_req;
            vec.vector <= VECTOR_OFFSET + {2'h0, win_req};
            vec.addr   <= win_addr;
            vec.prio   <= win_prio;
        end
    end

    // request to core only above its present level; level 8+ masks all
    assign irq_to_core = vec.valid && ({1'b0, vec.prio} > core_level);

    ////////////////////////////////////////////////////////////////////////////
    // read path: one cycle latency, zero in cycles without rd
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (bus.rd) begin
            if (bus.addr <= ADDR_PRIO_12) begin
                rdata_q <= prio_q[bus.addr];
            end else if (bus.addr == ADDR_CTRL) begin
                rdata_q <= {15'h0000, tbl_sel_q};
            end else if (bus.addr == ADDR_STATUS) begin
                rdata_q <= {6'h00, vec.valid, vec.prio, vec.req};
            end else begin
                rdata_q <= vec.addr[15:0];
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign rdata = rdata_q;

    // extra sources feed no vector here; kept for the core's wider table
    logic unused_extra;
    assign unused_extra = ^extra_src;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_ext0_win;
        irq_src[REQ_EXT0] && live[REQ_EXT0] && prio_of[REQ_EXT0] == 3'h7;
    endsequence

    ext0_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ext0_win |=> vec.req == 6'h00 && vec.addr == ($past(tbl_sel_q) ? 24'h000114 : 24'h000014))
        else $error("ext irq 0 entry wrong");
    dma0_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        (win_req == 6'd4) |=> vec.addr == ($past(tbl_sel_q) ? 24'h00011C : 24'h00001C))
        else $error("dma0 entry wrong");
    uart2_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        (win_req == 6'd31 && !tbl_sel_q) |=> vec.addr == 24'h000052 && vec.vector == 8'd39)
        else $error("uart2 tx entry wrong");
    comp8_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        (win_req == 6'd44 && !tbl_sel_q) |=> vec.addr == 24'h00006C)
        else $error("compare 8 entry wrong");
    reserved_never_a: assert property (@(posedge clk) disable iff (!rst_n)
        vec.valid |-> !(vec.req inside {6'd15, 6'd18, 6'd45}))
        else $error("reserved request chosen");
    disabled_never_a: assert property (@(posedge clk) disable iff (!rst_n)
        vec.valid |-> vec.prio != 3'h0)
        else $error("disabled source chosen");
    tie_lower_a: assert property (@(posedge clk) disable iff (!rst_n)
        (live[0] && live[1] && prio_of[0] == prio_of[1] && prio_of[0] == 3'h7) |=> vec.req == 6'h00)
        else $error("tie not to lower number");
    prio7_gaps_a: assert property (@(posedge clk) disable iff (!rst_n)
        (prio_q[7] & 16'h8888) == 16'h0000)
        else $error("register 7 gap bits set");
    prio11_gaps_a: assert property (@(posedge clk) disable iff (!rst_n)
        prio_q[11][7:3] == 5'h00)
        else $error("register 11 bits 7-3 set");
    level_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        core_level_top_bit |-> !irq_to_core)
        else $error("request above level 7 masked core");

    ////////////////////////////////////////////////////////////////////////////
    // reset values as seen at the first edge after release
    sequence s_out_of_reset;
        !$past(rst_n);
    endsequence

    reset_words_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_out_of_reset |-> prio_q[7] == 16'h4444 && prio_q[12] == 16'h4444)
        else $error("priority word reset wrong");
    reset_word11_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_out_of_reset |-> prio_q[11] == 16'h4404)
        else $error("register 11 reset wrong");
    reset_table_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_out_of_reset |-> !tbl_sel_q && !vec.valid)
        else $error("table select or choice not reset");

    ////////////////////////////////////////////////////////////////////////////
    // core level compare while the top bit is clear
    sequence s_level_low;
        vec.valid && !core_level_top_bit;
    endsequence

    level_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_level_low |-> irq_to_core == (vec.prio > core_status_level))
        else $error("level compare wrong");

    ////////////////////////////////////////////////////////////////////////////
    // priority beats request number when nothing lower is pending
    sequence s_uart2_pair;
        live[31] && live[30] && prio_of[31] == 3'h7 && prio_of[30] != 3'h7 && live[29:0] == 30'h0;
    endsequence

    prio_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_uart2_pair |=> vec.req == 6'h1F)
        else $error("higher priority lost");

    ////////////////////////////////////////////////////////////////////////////
    // alternate table entry
    sequence s_req30_alternate;
        win_req == 6'h1E && tbl_sel_q;
    endsequence

    uart2_alt_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req30_alternate |=> vec.addr == 24'h000150)
        else $error("uart2 rx alternate entry wrong");

    ////////////////////////////////////////////////////////////////////////////
    // primary entries, one per request number exercised

    sequence s_req1_primary;
        win_req == 6'h01 && !tbl_sel_q;
    endsequence
    cap1_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req1_primary |=> vec.addr == 24'h000016)
        else $error("capture 1 entry wrong");

    sequence s_req2_primary;
        win_req == 6'h02 && !tbl_sel_q;
    endsequence
    comp1_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req2_primary |=> vec.addr == 24'h000018)
        else $error("compare 1 entry wrong");

    sequence s_req9_primary;
        win_req == 6'h09 && !tbl_sel_q;
    endsequence
    spi1_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req9_primary |=> vec.addr == 24'h000026)
        else $error("spi1 error entry wrong");

    sequence s_req10_primary;
        win_req == 6'h0A && !tbl_sel_q;
    endsequence
    spi1_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req10_primary |=> vec.addr == 24'h000028)
        else $error("spi1 done entry wrong");

    sequence s_req11_primary;
        win_req == 6'h0B && !tbl_sel_q;
    endsequence
    uart1_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req11_primary |=> vec.addr == 24'h00002A)
        else $error("uart1 rx entry wrong");

    sequence s_req12_primary;
        win_req == 6'h0C && !tbl_sel_q;
    endsequence
    uart1_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req12_primary |=> vec.addr == 24'h00002C)
        else $error("uart1 tx entry wrong");

    sequence s_req14_primary;
        win_req == 6'h0E && !tbl_sel_q;
    endsequence
    dma1_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req14_primary |=> vec.addr == 24'h000030)
        else $error("dma1 entry wrong");

    sequence s_req16_primary;
        win_req == 6'h10 && !tbl_sel_q;
    endsequence
    i2c1_slave_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req16_primary |=> vec.addr == 24'h000034)
        else $error("i2c1 slave entry wrong");

    sequence s_req17_primary;
        win_req == 6'h11 && !tbl_sel_q;
    endsequence
    i2c1_master_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req17_primary |=> vec.addr == 24'h000036)
        else $error("i2c1 master entry wrong");

    sequence s_req20_primary;
        win_req == 6'h14 && !tbl_sel_q;
    endsequence
    ext1_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req20_primary |=> vec.addr == 24'h00003C)
        else $error("ext irq 1 entry wrong");

    sequence s_req22_primary;
        win_req == 6'h16 && !tbl_sel_q;
    endsequence
    cap7_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req22_primary |=> vec.addr == 24'h000040)
        else $error("capture 7 entry wrong");

    sequence s_req23_primary;
        win_req == 6'h17 && !tbl_sel_q;
    endsequence
    cap8_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req23_primary |=> vec.addr == 24'h000042)
        else $error("capture 8 entry wrong");

    sequence s_req24_primary;
        win_req == 6'h18 && !tbl_sel_q;
    endsequence
    dma2_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req24_primary |=> vec.addr == 24'h000044)
        else $error("dma2 entry wrong");

    sequence s_req30_primary;
        win_req == 6'h1E && !tbl_sel_q;
    endsequence
    uart2_rx_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req30_primary |=> vec.addr == 24'h000050)
        else $error("uart2 rx entry wrong");

    sequence s_req36_primary;
        win_req == 6'h24 && !tbl_sel_q;
    endsequence
    dma3_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req36_primary |=> vec.addr == 24'h00005C)
        else $error("dma3 entry wrong");

    sequence s_req37_primary;
        win_req == 6'h25 && !tbl_sel_q;
    endsequence
    cap3_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req37_primary |=> vec.addr == 24'h00005E)
        else $error("capture 3 entry wrong");

    sequence s_req40_primary;
        win_req == 6'h28 && !tbl_sel_q;
    endsequence
    cap6_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req40_primary |=> vec.addr == 24'h000064)
        else $error("capture 6 entry wrong");

    sequence s_req41_primary;
        win_req == 6'h29 && !tbl_sel_q;
    endsequence
    comp5_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_req41_primary |=> vec.addr == 24'h000066)
        else $error("compare 5 entry wrong");

endmodule // irq_vec

`default_nettype wire

// file: dv/core_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// core stand-in: owns the running level, fetches the offered vector
module core_model
    import irq_vec_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  level_set,          // level asked by the bench
    input  wire vec_out_t    vec,                // offered choice
    input  wire logic        irq_to_core,        // offer above our level
    output logic [2:0]       core_status_level,  // status field part
    output logic             core_level_top_bit, // set means level above 7
    output logic [23:0]      fetch_addr_q        // last fetched entry
);
    // level split into top bit over three-bit status field
    assign core_level_top_bit = level_set[3];
    assign core_status_level  = level_set[2:0];

    // fetch the entry whenever an offer is raised
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fetch_addr_q <= 24'h000000;
        end else if (irq_to_core) begin
            fetch_addr_q <= vec.addr;
        end
    end
endmodule // core_model

`default_nettype wire

// file: dv/test_interrupt_vector_priority.sv
`timescale 1ns/1ps
`default_nettype none

module test_interrupt_vector_priority
    import irq_vec_pkg::*;
;
    typedef struct packed {logic [5:0] req; logic [23:0] addr;} row_t;
    logic clk = 1'b0;
    logic rst_n;
    bus_req_t bus;
    logic [15:0] rdata;
    logic [45:0] irq_src;
    logic [5:0] extra_src;
    logic [3:0] level_set;
    vec_out_t vec;
    logic irq_to_core;
    logic [2:0] core_status_level;
    logic core_level_top_bit;
    logic [23:0] fetch_addr;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    // request number beside its primary entry
    row_t rows [0:21] = '{'{6'd0, 24'h000014}, '{6'd1, 24'h000016}, '{6'd2, 24'h000018},
        '{6'd4, 24'h00001C}, '{6'd9, 24'h000026}, '{6'd10, 24'h000028}, '{6'd11, 24'h00002A},
        '{6'd12, 24'h00002C}, '{6'd14, 24'h000030}, '{6'd16, 24'h000034}, '{6'd17, 24'h000036},
        '{6'd20, 24'h00003C}, '{6'd22, 24'h000040}, '{6'd23, 24'h000042}, '{6'd24, 24'h000044},
        '{6'd30, 24'h000050}, '{6'd31, 24'h000052}, '{6'd36, 24'h00005C}, '{6'd37, 24'h00005E},
        '{6'd40, 24'h000064}, '{6'd41, 24'h000066}, '{6'd44, 24'h00006C}};
    int rsv [0:2] = '{15, 18, 45};

    irq_vec u_irq_vec (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .irq_src(irq_src),
        .extra_src(extra_src), .core_status_level(core_status_level),
        .core_level_top_bit(core_level_top_bit), .vec(vec), .irq_to_core(irq_to_core));
    core_model u_core_model (.clk(clk), .rst_n(rst_n), .level_set(level_set), .vec(vec),
        .irq_to_core(irq_to_core), .core_status_level(core_status_level),
        .core_level_top_bit(core_level_top_bit), .fetch_addr_q(fetch_addr));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // pending flags, then let the choice register settle
    task automatic set_irq(input logic [45:0] v, input logic [3:0] lv);
        @(posedge clk);
        irq_src <= v;
        level_set <= lv;
        repeat (2) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        irq_src = '0;
        extra_src = '0;
        level_set = 4'h0;
        bus = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_PRIO_7, 16'h4444);
        rd_chk(ADDR_PRIO_11, 16'h4404);
        rd_chk(ADDR_PRIO_12, 16'h4444);
        foreach (rows[i]) begin
            set_irq(46'h1 << rows[i].req, 4'h0);
            chk(vec.addr, rows[i].addr);
            chk({16'h0, vec.vector}, {16'h0, 8'(rows[i].req) + 8'h08});
            chk({23'h0, irq_to_core}, 24'h000001);
        end
        foreach (rsv[i]) begin
            set_irq(46'h1 << rsv[i], 4'h0);
            chk({17'h0, vec.valid, vec.req}, {18'h0, 6'h3F});
        end
        wr(ADDR_PRIO_11, 16'hFFFF);
        rd_chk(ADDR_PRIO_11, 16'h7707);
        wr(ADDR_PRIO_7, 16'hFFFF);
        rd_chk(ADDR_PRIO_7, 16'h7777);
        set_irq(46'h0000_C000_0000, 4'h0);
        chk({18'h0, vec.req}, 24'd30);
        wr(ADDR_PRIO_7, 16'h7444);
        set_irq(46'h0000_C000_0000, 4'h8);
        chk({15'h0, vec.prio, vec.req}, {15'h0, 3'h7, 6'd31});
        chk({23'h0, irq_to_core}, 24'h000000);
        wr(ADDR_PRIO_7, 16'h4440);
        set_irq(46'h0000_1000_0000, 4'h0);
        chk({23'h0, vec.valid}, 24'h000000);
        wr(ADDR_PRIO_7, 16'h4441);
        set_irq(46'h0000_1000_0000, 4'h1);
        chk({15'h0, vec.prio, vec.req}, {15'h0, 3'h1, 6'd28});
        chk({23'h0, irq_to_core}, 24'h000000);
        wr(ADDR_PRIO_BASE, 16'h0077);
        set_irq(46'h3, 4'h0);
        chk({18'h0, vec.req}, 24'd0);
        chk(vec.addr, 24'h000014);
        wr(ADDR_CTRL, 16'h0001);
        set_irq(46'h0000_4000_0000, 4'h3);
        chk(vec.addr, 24'h000150);
        rd_chk(ADDR_STATUS, 16'h031E);
        chk(fetch_addr, 24'h000150);
        // mid-run reset: table select and words go back
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(ADDR_CTRL, 16'h0000);
        rd_chk(ADDR_PRIO_7, 16'h4444);
        chk(vec.addr, 24'h000050);
        stop_test();
    end
endmodule // test_interrupt_vector_priority

`default_nettype wire
